// [hw/led_pkg.sv]
// constants for the fault and activity indicator logic
// assumes a single 100 MHz clock
package led_pkg;
    localparam int unsigned clk_hz = 100000000;
    // blink timing in milliseconds
    localparam int unsigned blink_on_ms = 200;
    localparam int unsigned blink_off_ms = 200;
    localparam int unsigned group_pause_ms = 1000;
    localparam int unsigned ms_cycles = clk_hz / 1000;
    localparam logic [31:0] blink_on_cycles = 32'(blink_on_ms * ms_cycles);
    localparam logic [31:0] blink_off_cycles = 32'(blink_off_ms * ms_cycles);
    localparam logic [31:0] pause_cycles = 32'(group_pause_ms * ms_cycles);
    // blink counts per error code
    localparam logic [1:0] blinks_none = 2'h0;
    localparam logic [1:0] blinks_unprog = 2'h2;
    localparam logic [1:0] blinks_wrong_fw = 2'h3;
    // width of the rail-enable vector for one output signal
    localparam int unsigned rail_w = 8;
    // fault cause bits in the report word
    localparam int unsigned cause_w = 7;
    localparam int unsigned cause_ov = 0;
    localparam int unsigned cause_oc = 1;
    localparam int unsigned cause_cfg = 2;
    localparam int unsigned cause_drv = 3;
    localparam int unsigned cause_model = 4;
    localparam int unsigned cause_unprog = 5;
    localparam int unsigned cause_wrong_fw = 6;
    typedef enum logic [3:0] {
        st_idle  = 4'h1,
        st_on    = 4'h2,
        st_off   = 4'h4,
        st_pause = 4'h8
    } blink_state_t;
endpackage

// [hw/blink_gen.sv]
// blink group generator: repeats groups of n blinks with a pause
// assumes count is held steady while enable is high
`timescale 1ns/1ps
module blink_gen #(
    parameter logic [31:0] on_cycles = led_pkg::blink_on_cycles,
    parameter logic [31:0] off_cycles = led_pkg::blink_off_cycles,
    parameter logic [31:0] pause_cycles = led_pkg::pause_cycles
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic [1:0] count,
    output logic lamp
);
    led_pkg::blink_state_t state_reg;
    led_pkg::blink_state_t state_next;
    logic [31:0] timer_reg;
    logic [31:0] timer_next;
    logic [1:0] done_reg;
    logic [1:0] done_next;
    logic lamp_next;
    wire expired = (timer_reg == 32'h0);
    wire last_blink = ((done_reg + 2'h1) >= count);

    // -----------------------------------------
    // sequencer
    // -----------------------------------------
    always_comb
    begin
        state_next = state_reg;
        timer_next = expired ? timer_reg : timer_reg - 32'h1;
        done_next = done_reg;
        case (state_reg)
            led_pkg::st_idle:
            begin
                done_next = 2'h0;
                if (enable && count != 2'h0)
                begin
                    state_next = led_pkg::st_on;
                    timer_next = on_cycles - 32'h1;
                end
            end
            led_pkg::st_on:
                if (expired)
                begin
                    done_next = done_reg + 2'h1;
                    state_next = last_blink ? led_pkg::st_pause
                                            : led_pkg::st_off;
                    timer_next = last_blink ? pause_cycles - 32'h1
                                            : off_cycles - 32'h1;
                end
            led_pkg::st_off:
                if (expired)
                begin
                    state_next = led_pkg::st_on;
                    timer_next = on_cycles - 32'h1;
                end
            led_pkg::st_pause:
                if (expired)
                begin
                    done_next = 2'h0;
                    state_next = led_pkg::st_on;
                    timer_next = on_cycles - 32'h1;
                end
            default:
                state_next = led_pkg::st_idle;
        endcase
        if (!enable)
        begin
            state_next = led_pkg::st_idle;
        end
        lamp_next = (state_next == led_pkg::st_on);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= led_pkg::st_idle;
            timer_reg <= 32'h0;
            done_reg <= 2'h0;
            lamp <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            done_reg <= done_next;
            lamp <= lamp_next;
        end
    end
endmodule

// [hw/fault_status_led_indicator.sv]
// fault and activity indicator logic of the simulator base module
// assumes all inputs synchronous to clk; realtime_host_unit clears faults
`timescale 1ns/1ps
module fault_status_led_indicator #(
    parameter logic [31:0] on_cycles = led_pkg::blink_on_cycles,
    parameter logic [31:0] off_cycles = led_pkg::blink_off_cycles,
    parameter logic [31:0] pause_cycles = led_pkg::pause_cycles
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic logic_configured,
    input wire logic link_reset_done,
    input wire logic logic_unprogrammed,
    input wire logic firmware_mismatch,
    input wire logic overvoltage,
    input wire logic overcurrent,
    input wire logic driver_select_invalid,
    input wire logic model_condition_invalid,
    input wire logic [led_pkg::rail_w-1:0] rail_enable_req,
    input wire logic fault_clear,
    output logic [led_pkg::rail_w-1:0] rail_enable_out,
    output logic yellow_led,
    output logic red_led,
    output logic [led_pkg::cause_w-1:0] fault_cause,
    output logic fault_report
);
    // -----------------------------------------
    // configuration check
    // -----------------------------------------
    function automatic logic many_set(input logic [led_pkg::rail_w-1:0] v);
        logic [led_pkg::rail_w-1:0] low;
        low = v & (v - 1'b1);
        return low != '0;
    endfunction

    wire cfg_invalid = many_set(rail_enable_req);
    wire [led_pkg::cause_w-1:0] events = {
        firmware_mismatch,
        logic_unprogrammed,
        model_condition_invalid,
        driver_select_invalid,
        cfg_invalid,
        overcurrent,
        overvoltage
    };
    logic [led_pkg::cause_w-1:0] cause_next;
    logic [led_pkg::rail_w-1:0] rail_next;

    // sticky causes; a new event wins over a clear
    assign cause_next = (fault_clear ? '0 : fault_cause) | events;

    // hold last valid setting while the request is invalid
    assign rail_next = cfg_invalid ? rail_enable_out : rail_enable_req;

    // -----------------------------------------
    // indicator selection
    // -----------------------------------------
    wire fault_any = (cause_next != '0);
    wire code_unprog = cause_next[led_pkg::cause_unprog];
    wire code_wrong = cause_next[led_pkg::cause_wrong_fw];
    wire [1:0] blink_count = code_wrong ? led_pkg::blinks_wrong_fw
                           : code_unprog ? led_pkg::blinks_unprog
                           : led_pkg::blinks_none;
    wire blinking = fault_any && (blink_count != led_pkg::blinks_none);
    wire activity = logic_configured && link_reset_done;
    logic blink_lamp;
    logic yellow_next;

    blink_gen #(
        .on_cycles(on_cycles),
        .off_cycles(off_cycles),
        .pause_cycles(pause_cycles)
    ) u_blink (
        .clk(clk),
        .reset_n(reset_n),
        .enable(blinking),
        .count(blink_count),
        .lamp(blink_lamp)
    );

    // activity when no fault, steady on for general error, code pattern for unprogrammed or wrong firmware
    assign yellow_next = !fault_any ? activity
                       : blinking ? blink_lamp
                       : 1'b1;

    // -----------------------------------------
    // output registers
    // -----------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fault_cause <= '0;
            rail_enable_out <= '0;
            red_led <= 1'b0;
            fault_report <= 1'b0;
            yellow_led <= 1'b0;
        end
        else
        begin
            fault_cause <= cause_next;
            rail_enable_out <= rail_next;
            red_led <= fault_any;
            fault_report <= fault_any;
            yellow_led <= yellow_next;
        end
    end
endmodule

// [tb/fault_led_checker_asserts.sv]
// checker on the indicator block ports
// assumes fault inputs held low in reset
`timescale 1ns/1ps
module fault_led_checker
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic logic_configured,
    input wire logic link_reset_done,
    input wire logic overvoltage,
    input wire logic driver_select_invalid,
    input wire logic [led_pkg::rail_w-1:0] rail_enable_req,
    input wire logic [led_pkg::rail_w-1:0] rail_enable_out,
    input wire logic yellow_led,
    input wire logic red_led,
    input wire logic [led_pkg::cause_w-1:0] fault_cause,
    input wire logic fault_report
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire bad_req = $countones(rail_enable_req) > 1;
    a_red_report: assert property
        (fault_report == red_led && red_led == (|fault_cause))
        else $error("red or report wrong");
    a_ov_cause: assert property
        (overvoltage |=> fault_cause[0]) else $error("ov not latched");
    a_cfg_cause: assert property
        (bad_req |=> fault_cause[2]) else $error("rails not latched");
    a_drv_cause: assert property
        (driver_select_invalid |=> fault_cause[3]) else $error("drv");
    a_rail_hold: assert property
        (bad_req |=> $stable(rail_enable_out)) else $error("rail moved");
    a_rail_apply: assert property
        (!bad_req |=> rail_enable_out == $past(rail_enable_req))
        else $error("rail not applied");
    a_steady_yellow: assert property
        ((red_led && fault_cause[6:5] == 2'h0) [*2] |-> yellow_led)
        else $error("yellow not steady");
    a_idle_yellow: assert property
        (!red_led && !$past(red_led) |-> yellow_led ==
        ($past(logic_configured) && $past(link_reset_done)))
        else $error("activity");
    c_fault_steady: cover property (red_led && yellow_led);
    c_bad_rails: cover property (bad_req ##1 red_led);
    c_blink: cover property (fault_cause[6] && $rose(yellow_led));
endmodule
bind fault_status_led_indicator fault_led_checker i_chk (.clk, .reset_n,
    .logic_configured, .link_reset_done, .overvoltage,
    .driver_select_invalid, .rail_enable_req, .rail_enable_out,
    .yellow_led, .red_led, .fault_cause, .fault_report);

// [tb/host_unit_model.sv]
// host unit model: resets the link, clears reported faults
// assumes clr_req is a one-cycle request from the bench
`timescale 1ns/1ps
module host_unit_model
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clr_req,
    input wire logic fault_report,
    output logic link_reset_done,
    output logic fault_clear
);
    logic [3:0] up_reg;
    assign link_reset_done = up_reg[3];
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            {up_reg, fault_clear} <= 5'h00;
        else
            {up_reg, fault_clear} <= {up_reg + 4'(!up_reg[3]),
                clr_req && fault_report};
    end
endmodule

// [tb/tb_fault_status_led_indicator.sv]
// bench for the indicator block with a host unit model
// assumes short blink timing 4/4/12 cycles
`timescale 1ns/1ps
module tb_fault_status_led_indicator;
    logic clk = 1'b0, reset_n = 1'b0, cfg = 1'b0, clr_req = 1'b0;
    logic unprog = 1'b0, fw_bad = 1'b0, link, clr, yel, red, rep;
    logic [3:0] fv = 4'h0;
    logic [7:0] req = 8'h00, rout;
    logic [6:0] cause;
    int mismatches = 0, compares = 0;
    host_unit_model i_host (.clk(clk), .reset_n(reset_n), .clr_req(clr_req),
        .fault_report(rep), .link_reset_done(link), .fault_clear(clr));
    fault_status_led_indicator #(.on_cycles(32'h4), .off_cycles(32'h4),
        .pause_cycles(32'hc)) i_dut (.clk(clk), .reset_n(reset_n),
        .logic_configured(cfg), .link_reset_done(link),
        .logic_unprogrammed(unprog), .firmware_mismatch(fw_bad),
        .overvoltage(fv[0]), .overcurrent(fv[1]),
        .driver_select_invalid(fv[2]), .model_condition_invalid(fv[3]),
        .rail_enable_req(req), .fault_clear(clr), .rail_enable_out(rout),
        .yellow_led(yel), .red_led(red), .fault_cause(cause),
        .fault_report(rep));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic clear_faults;
        clr_req = 1'b1;
        step(1);
        clr_req = 1'b0;
        step(2);
    endtask
    // one group lasts 8n+8 cycles; count over two groups
    task automatic check_blink(input int n);
        int hi;
        int rise;
        logic last;
        hi = 0;
        rise = 0;
        step(40);
        last = yel;
        repeat (16 * n + 16)
        begin
            step(1);
            hi += int'(yel === 1'b1);
            rise += int'(yel === 1'b1 && last === 1'b0);
            last = yel;
        end
        check(8'(hi), 8'(8 * n));
        check(8'(rise), 8'(2 * n));
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        forever #5 clk = ~clk;
    end
    initial
    begin
        #20000;
        mismatches++;
        test_done();
    end
    initial
    begin
        step(8);
        reset_n = 1'b1;
        step(10);
        check({5'h0, red, rep, yel}, 8'h00);
        cfg = 1'b1;
        step(2);
        check({5'h0, red, rep, yel}, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            fv = 4'(1 << i);
            step(1);
            fv = 4'h0;
            step(1);
            check({1'b0, cause}, 8'(i < 2 ? 1 << i : 2 << i));
            check({5'h0, red, rep, yel}, 8'h07);
            clear_faults();
            check({red, cause}, 8'h00);
        end
        req = 8'h04;
        step(2);
        check(rout, 8'h04);
        req = 8'h05;
        step(2);
        check(rout, 8'h04);
        check({1'b0, cause}, 8'h04);
        req = 8'h00;
        step(1);
        clear_faults();
        check(rout, 8'h00);
        unprog = 1'b1;
        check_blink(2);
        fw_bad = 1'b1;
        check_blink(3);
        check({6'h0, red, rep}, 8'h03);
        {unprog, fw_bad} = 2'h0;
        step(1);
        clear_faults();
        check({red, cause}, 8'h00);
        test_done();
    end
endmodule
